//--- crbs_pkg.sv
// shared constants, option struct and sequencer states for the readback serializer
// assumes a single reference clock domain; frame contents come from same-domain logic
package crbs_pkg;

  localparam int DUMMY_BITS = 5;
  localparam int CHECK_BITS = 4;
  localparam int LAST_ONES = 7;
  localparam int CRC_BITS = 11;
  localparam int LOAD_LEAD = 6;

  // crc polynomial and seed: values arbitrary, not tied to any real part
  localparam logic [CRC_BITS-1:0] CRC_POLY = 11'h385;
  localparam logic [CRC_BITS-1:0] CRC_SEED = 11'h000;

  localparam logic BIT_HIGH = 1'b1;
  localparam logic BIT_START = 1'b0;

  // options fixed by the loaded configuration
  typedef struct packed {
    logic capture_en;
    logic abort_en;
    logic user_clk_sel;
  } crbs_opts_t;

  localparam crbs_opts_t OPTS_RESET = '{capture_en: 1'b0, abort_en: 1'b0, user_clk_sel: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_DUMMY,
    ST_START,
    ST_DATA,
    ST_CHECK,
    ST_CRC_START,
    ST_CRC_OUT
  } crbs_state_t;

endpackage

//--- crbs_readback.sv
// readback serializer: frames configuration, ram and captured cell state into a bit stream
// assumes trigger, both readback clocks and the connect strap come from outside ref_clk_i;
// frame inputs are same-domain and valid for frame_idx_o one ref_clk_i cycle after it changes
`timescale 1ns/1ps

module crbs_readback #(
  parameter int FRAME_BITS = 64,
  parameter int NUM_FRAMES = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire crbs_pkg::crbs_opts_t opts_i,
  input wire logic nets_connected_i,
  input wire logic readback_trigger_i,
  input wire logic config_clock_i,
  input wire logic readback_clock_in_i,
  input wire logic [FRAME_BITS-1:0] frame_cfg_i,
  input wire logic [FRAME_BITS-1:0] frame_ram_i,
  input wire logic [FRAME_BITS-1:0] frame_ram_used_i,
  input wire logic [FRAME_BITS-1:0] frame_cap_pos_i,
  input wire logic [FRAME_BITS-1:0] frame_cap_val_i,
  output logic [$clog2(NUM_FRAMES+1)-1:0] frame_idx_o,
  output logic capture_strobe_o,
  output logic readback_serial_out_o,
  output logic read_in_progress_o
);

  localparam int IW = $clog2(NUM_FRAMES + 1);
  localparam int CW = $clog2(FRAME_BITS + crbs_pkg::CRC_BITS + crbs_pkg::DUMMY_BITS + 1);
  localparam int FORCE_TAIL = crbs_pkg::LAST_ONES - crbs_pkg::CHECK_BITS;

  // refused at elaboration: the load point needs LOAD_LEAD bits inside one frame
  if (FRAME_BITS < crbs_pkg::LOAD_LEAD || NUM_FRAMES < 1) begin
    $error("crbs_readback: FRAME_BITS must be at least LOAD_LEAD and NUM_FRAMES at least 1");
  end

  // build one outgoing frame word from the array's views of it
  function automatic logic [FRAME_BITS-1:0] compose(
    input logic [FRAME_BITS-1:0] cfg,
    input logic [FRAME_BITS-1:0] ram,
    input logic [FRAME_BITS-1:0] ram_used,
    input logic [FRAME_BITS-1:0] cap_pos,
    input logic [FRAME_BITS-1:0] cap_val,
    input logic cap_en,
    input logic last
  );
    logic [FRAME_BITS-1:0] w;
    w = (cfg & ~ram_used) | (ram & ram_used);
    if (cap_en) begin
      w = (w & ~cap_pos) | (~cap_val & cap_pos);
    end
    if (last) begin
      for (int i = FRAME_BITS - FORCE_TAIL; i < FRAME_BITS; i++) begin
        w[i] = crbs_pkg::BIT_HIGH;
      end
    end
    return w;
  endfunction

  function automatic logic [crbs_pkg::CRC_BITS-1:0] crc_step(
    input logic [crbs_pkg::CRC_BITS-1:0] c,
    input logic b
  );
    logic fb;
    fb = b ^ c[crbs_pkg::CRC_BITS-1];
    return {c[crbs_pkg::CRC_BITS-2:0], 1'b0} ^ (fb ? crbs_pkg::CRC_POLY : '0);
  endfunction

  // two-flop synchronisers; only the second stage is read
  logic [1:0] trig_sync_q, config_clock_sync_q, uclk_sync_q, conn_sync_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_sync_q <= '0;
      config_clock_sync_q <= '0;
      uclk_sync_q <= '0;
      conn_sync_q <= '0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], readback_trigger_i};
      config_clock_sync_q <= {config_clock_sync_q[0], config_clock_i};
      uclk_sync_q <= {uclk_sync_q[0], readback_clock_in_i};
      conn_sync_q <= {conn_sync_q[0], nets_connected_i};
    end
  end

  // options frozen on the first edge after reset; no run-time path changes them
  crbs_pkg::crbs_opts_t opts_q;
  logic opts_valid_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      opts_q <= crbs_pkg::OPTS_RESET;
      opts_valid_q <= 1'b0;
    end else if (!opts_valid_q) begin
      opts_q <= opts_i;
      opts_valid_q <= 1'b1;
    end
  end

  // edge detection on synchronised levels
  logic trig_prev_q, rk_prev_q;
  logic rk_level, rk_rise, trig_rise, trig_fall;
  assign rk_level = opts_q.user_clk_sel ? uclk_sync_q[1] : config_clock_sync_q[1];
  assign rk_rise = rk_level & ~rk_prev_q;
  assign trig_rise = trig_sync_q[1] & ~trig_prev_q;
  assign trig_fall = ~trig_sync_q[1] & trig_prev_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
      rk_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sync_q[1];
      rk_prev_q <= rk_level;
    end
  end

  crbs_pkg::crbs_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [IW-1:0] cur_q;
  logic [FRAME_BITS-1:0] sh_q, next_q;
  logic [crbs_pkg::CRC_BITS-1:0] crc_q;
  logic last_frame, load_now, abort_now;

  assign last_frame = (cur_q == IW'(NUM_FRAMES - 1));
  // loading is a dynamic step, hence the controller's timing limits near start bits
  assign load_now = rk_rise && ((state_q == crbs_pkg::ST_ARMED) ||
                    (state_q == crbs_pkg::ST_DATA && cnt_q == CW'(FRAME_BITS - 2) && !last_frame));
  // abort only matters once armed; unconnected nets never arm
  assign abort_now = opts_q.abort_en && trig_fall && state_q != crbs_pkg::ST_IDLE;

  // frame fetch: frame_idx_o points at the frame that the next load takes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort_now || state_q == crbs_pkg::ST_IDLE) begin
      frame_idx_o <= '0;
      next_q <= '0;
    end else if (load_now) begin
      next_q <= compose(frame_cfg_i, frame_ram_i, frame_ram_used_i, frame_cap_pos_i, frame_cap_val_i,
                        opts_q.capture_en, frame_idx_o == IW'(NUM_FRAMES - 1));
      frame_idx_o <= frame_idx_o + IW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      capture_strobe_o <= 1'b0;
    end else begin
      capture_strobe_o <= state_q == crbs_pkg::ST_IDLE && trig_rise && conn_sync_q[1] &&
                          opts_valid_q && opts_q.capture_en;
    end
  end

  // sequencer: each selected-clock rising edge outside ST_IDLE emits exactly one bit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort_now) begin
      state_q <= crbs_pkg::ST_IDLE;
      cnt_q <= '0;
      cur_q <= '0;
      sh_q <= '0;
      crc_q <= crbs_pkg::CRC_SEED;
      readback_serial_out_o <= crbs_pkg::BIT_HIGH;
      read_in_progress_o <= 1'b0;
    end else begin
      case (state_q)
        crbs_pkg::ST_IDLE: begin
          // busy readback never reaches here, so a repeat trigger is ignored
          if (trig_rise && conn_sync_q[1] && opts_valid_q) begin
            state_q <= crbs_pkg::ST_ARMED;
          end
        end
        crbs_pkg::ST_ARMED: begin
          if (rk_rise) begin
            read_in_progress_o <= 1'b1;
            readback_serial_out_o <= crbs_pkg::BIT_HIGH;
            crc_q <= crbs_pkg::CRC_SEED;
            cnt_q <= CW'(1);
            state_q <= crbs_pkg::ST_DUMMY;
          end
        end
        crbs_pkg::ST_DUMMY: begin
          if (rk_rise) begin
            if (cnt_q < CW'(crbs_pkg::DUMMY_BITS)) begin
              readback_serial_out_o <= crbs_pkg::BIT_HIGH;
              cnt_q <= cnt_q + CW'(1);
            end else begin
              readback_serial_out_o <= crbs_pkg::BIT_START;
              sh_q <= next_q;
              state_q <= crbs_pkg::ST_START;
            end
          end
        end
        crbs_pkg::ST_START, crbs_pkg::ST_DATA: begin
          if (rk_rise) begin
            if (state_q == crbs_pkg::ST_START || cnt_q < CW'(FRAME_BITS)) begin
              readback_serial_out_o <= sh_q[0];
              crc_q <= crc_step(crc_q, sh_q[0]);
              sh_q <= sh_q >> 1;
              cnt_q <= (state_q == crbs_pkg::ST_START) ? CW'(1) : cnt_q + CW'(1);
              state_q <= crbs_pkg::ST_DATA;
            end else begin
              readback_serial_out_o <= crbs_pkg::BIT_HIGH;
              crc_q <= crc_step(crc_q, crbs_pkg::BIT_HIGH);
              cnt_q <= CW'(1);
              state_q <= crbs_pkg::ST_CHECK;
            end
          end
        end
        crbs_pkg::ST_CHECK: begin
          if (rk_rise) begin
            if (cnt_q < CW'(crbs_pkg::CHECK_BITS)) begin
              readback_serial_out_o <= crbs_pkg::BIT_HIGH;
              crc_q <= crc_step(crc_q, crbs_pkg::BIT_HIGH);
              cnt_q <= cnt_q + CW'(1);
            end else begin
              readback_serial_out_o <= crbs_pkg::BIT_START;
              if (last_frame) begin
                state_q <= crbs_pkg::ST_CRC_START;
              end else begin
                sh_q <= next_q;
                cur_q <= cur_q + IW'(1);
                state_q <= crbs_pkg::ST_START;
              end
            end
          end
        end
        crbs_pkg::ST_CRC_START, crbs_pkg::ST_CRC_OUT: begin
          if (rk_rise) begin
            if (state_q == crbs_pkg::ST_CRC_START || cnt_q < CW'(crbs_pkg::CRC_BITS)) begin
              readback_serial_out_o <= crc_q[crbs_pkg::CRC_BITS-1];
              crc_q <= {crc_q[crbs_pkg::CRC_BITS-2:0], 1'b0};
              cnt_q <= (state_q == crbs_pkg::ST_CRC_START) ? CW'(1) : cnt_q + CW'(1);
              state_q <= crbs_pkg::ST_CRC_OUT;
            end else begin
              readback_serial_out_o <= crbs_pkg::BIT_HIGH;
              read_in_progress_o <= 1'b0;
              cur_q <= '0;
              state_q <= crbs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= crbs_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- crbs_readback_asserts.sv
// port checker for the readback serializer
// assumes one ref_clk_i domain with synchronous rst_i
`timescale 1ns/1ps
module crbs_readback_asserts #(
  parameter int FRAME_BITS = 64,
  parameter int NUM_FRAMES = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic readback_trigger_i,
  input wire logic [$clog2(NUM_FRAMES+1)-1:0] frame_idx_o,
  input wire logic capture_strobe_o,
  input wire logic readback_serial_out_o,
  input wire logic read_in_progress_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_IDLE_HIGH: assert property (!read_in_progress_o |-> readback_serial_out_o)
    else $error("serial low while idle");
  AST_RESET_STATE: assert property ($fell(rst_i) |-> !read_in_progress_o && frame_idx_o == '0)
    else $error("bad state after reset");
  AST_BUSY_MIN: assert property ($rose(read_in_progress_o) |-> read_in_progress_o [*8])
    else $error("busy too short");
  AST_DUMMY_HOLD: assert property ($rose(read_in_progress_o) |-> readback_serial_out_o [*8])
    else $error("dummy bits not high");
  AST_TRIG_CAUSE: assert property ($rose(read_in_progress_o) |-> readback_trigger_i)
    else $error("busy without trigger");
  AST_STROBE_PULSE: assert property (capture_strobe_o |=> !capture_strobe_o)
    else $error("strobe longer than one cycle");
  AST_STROBE_IDLE: assert property (capture_strobe_o |-> !read_in_progress_o && readback_trigger_i)
    else $error("strobe outside trigger");
  AST_IDX_RANGE: assert property (frame_idx_o <= NUM_FRAMES)
    else $error("frame index out of range");
endmodule
bind crbs_readback crbs_readback_asserts #(.FRAME_BITS(FRAME_BITS), .NUM_FRAMES(NUM_FRAMES)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .readback_trigger_i(readback_trigger_i),
  .frame_idx_o(frame_idx_o), .capture_strobe_o(capture_strobe_o),
  .readback_serial_out_o(readback_serial_out_o), .read_in_progress_o(read_in_progress_o));

//--- crbs_ctrl_model.sv
// far-side controller model: trigger and readback clocks
// assumes the bench calls its tasks; clock idles low between bursts
`timescale 1ns/1ps
module crbs_ctrl_model (
  input wire logic user_sel_i,
  output logic trigger_o,
  output logic cfg_clk_o,
  output logic usr_clk_o
);
  logic rb_clk;
  initial begin
    trigger_o = 1'b0;
    rb_clk = 1'b0;
  end
  // unselected clock runs in antiphase so a wrong select shows
  assign cfg_clk_o = user_sel_i ? ~rb_clk : rb_clk;
  assign usr_clk_o = user_sel_i ? rb_clk : ~rb_clk;
  // 100 ns halves stay inside max high/low time at every bit
  task automatic clocks(input int n);
    repeat (n) begin
      rb_clk = 1'b1;
      #100;
      rb_clk = 1'b0;
      #100;
    end
  endtask
  task automatic set_trigger(input logic v);
    trigger_o = v;
  endtask
endmodule

//--- crbs_readback_tb.sv
// self-checking bench for the readback serializer
// assumes the controller model and bound checker are compiled alongside
`timescale 1ns/1ps
module crbs_readback_tb;
  localparam int FB = 8;
  localparam int NF = 2;
  localparam int SL = 5 + NF * (FB + 5) + 12;
  logic clk, rst, conn, usel, trig, config_clock, uclk, sout, busy, strobe, stb_seen;
  crbs_pkg::crbs_opts_t opts;
  logic [$clog2(NF+1)-1:0] idx;
  logic [FB-1:0] cfg[NF], ram[NF], used[NF], cpos[NF], cval[NF];
  logic [FB-1:0] f_cfg, f_ram, f_used, f_cpos, f_cval;
  int sel, n_errors = 0, n_compared = 0, cyc = 0;
  assign sel = (int'(idx) < NF) ? int'(idx) : NF - 1;
  // array side follows the frame index, as the array would
  assign f_cfg = cfg[sel];
  assign f_ram = ram[sel];
  assign f_used = used[sel];
  assign f_cpos = cpos[sel];
  assign f_cval = cval[sel];
  crbs_ctrl_model M (.user_sel_i(usel), .trigger_o(trig), .cfg_clk_o(config_clock), .usr_clk_o(uclk));
  crbs_readback #(.FRAME_BITS(FB), .NUM_FRAMES(NF)) DUT (.ref_clk_i(clk), .rst_i(rst), .opts_i(opts),
    .nets_connected_i(conn), .readback_trigger_i(trig), .config_clock_i(config_clock), .readback_clock_in_i(uclk),
    .frame_cfg_i(f_cfg), .frame_ram_i(f_ram), .frame_ram_used_i(f_used),
    .frame_cap_pos_i(f_cpos), .frame_cap_val_i(f_cval), .frame_idx_o(idx),
    .capture_strobe_o(strobe), .readback_serial_out_o(sout), .read_in_progress_o(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (strobe) stb_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [SL-1:0] exp_stream(input logic cap);
    logic [SL-1:0] s;
    logic [10:0] c;
    logic b;
    int p;
    s = '1;
    c = crbs_pkg::CRC_SEED;
    p = 5;
    for (int f = 0; f < NF; f++) begin
      s[p++] = 1'b0;
      for (int i = 0; i < FB + 4; i++) begin
        b = 1'b1;
        if (i < FB && !(f == NF - 1 && i >= FB - 3)) begin
          b = used[f][i] ? ram[f][i] : cfg[f][i];
          if (cap && cpos[f][i]) b = ~cval[f][i];
        end
        s[p++] = b;
        c = {c[9:0], 1'b0} ^ ((c[10] ^ b) ? crbs_pkg::CRC_POLY : 11'h000);
      end
    end
    s[p++] = 1'b0;
    for (int i = 10; i >= 0; i--) s[p++] = c[i];
    return s;
  endfunction
  task automatic start(input logic [2:0] o, input logic cn);
    opts = o;
    usel = o[0];
    conn = cn;
    rst = 1'b1;
    for (int f = 0; f < NF; f++) begin
      cfg[f] = FB'($urandom);
      ram[f] = FB'($urandom);
      used[f] = FB'($urandom);
      cpos[f] = FB'($urandom);
      cval[f] = FB'($urandom);
    end
    // first two data bits of frame zero must read high
    cfg[0][1:0] = 2'b11;
    used[0][1:0] = 2'b00;
    cpos[0][1:0] = 2'b00;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1 opts = ~opts;
  endtask
  task automatic readback(input logic cap, input int md);
    logic [SL-1:0] e;
    e = exp_stream(cap);
    stb_seen = 1'b0;
    M.set_trigger(1'b1);
    repeat (6) @(posedge clk);
    // keep every link change off the sampling edge
    #1;
    check(stb_seen, cap);
    for (int k = 0; k < SL; k++) begin
      if (k == 20 && md != 0) begin
        M.set_trigger(1'b0);
        repeat (6) @(posedge clk);
        #1;
        if (md == 2) begin
          check({busy, sout}, 2'b01);
          check(idx, 32'h0000_0000);
          M.clocks(NF);
          return;
        end
        M.set_trigger(1'b1);
        repeat (6) @(posedge clk);
        #1;
      end
      M.clocks(1);
      check({busy, sout}, {1'b1, e[k]});
    end
    M.clocks(1);
    check({busy, sout}, 2'b01);
    check(idx, 32'h0000_0000);
    M.set_trigger(1'b0);
  endtask
  initial begin
    void'($urandom(32'hf63e));
    start(3'b000, 1'b0);
    M.set_trigger(1'b1);
    repeat (6) @(posedge clk);
    #1;
    M.clocks(8);
    check({busy, sout}, 2'b01);
    M.set_trigger(1'b0);
    for (int m = 0; m < 4; m++) begin
      start({m[0], 1'b0, m[1]}, 1'b1);
      readback(m[0], int'(m == 3));
    end
    start(3'b010, 1'b1);
    readback(1'b0, 2);
    readback(1'b0, 0);
    complete_run;
  end
endmodule
